// ===== rtl/switch_queue_qos.sv
// Purpose: queue thresholds, pause/drop, WRR egress, priority resolution
// Assumes: datapath inputs are on core_clk_in; register port is same clock
// Notes: event status at offset 0x00, write 1 to clear
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "swq_cfg.svh"
module switch_queue_qos #(
  parameter int PORTS = 7
) (
  input wire logic core_clk_in, // 25 MHz switch clock
  input wire logic rst_b_in, // async reset, active low
  input wire swq_pkg::bus_req_t bus_in, // register request
  output logic [31:0] rdata_out, // read data, cycle after read
  input wire logic [8:0] free_blocks_in, // global free block count
  input wire swq_pkg::port_blk_t [6:0] queued_blocks_in, // per port/class
  input wire logic storm_in, // broadcast storm detected
  input wire logic [6:0] top_class_rx_in, // top-class frame seen per port
  input wire logic collision_in, // collision event pulse
  input wire logic [3:0] attempts_in, // back-off attempts so far
  input wire logic [3:0] queue_ready_in, // class has packet to send
  input wire logic sent_in, // granted packet sent
  input wire swq_pkg::cls_req_t cls_req_in, // classify request
  input wire logic igmp_in, // frame is IGMP
  input wire logic lookup_idle_in, // address engine idle
  output logic [6:0] pause_port_out, // pause per port
  output logic [6:0] drop_port_out, // drop per port
  output logic [1:0] grant_out, // egress class granted
  output logic grant_vld_out, // grant valid
  output logic [1:0] cls_out, // resolved class
  output logic cls_vld_out, // resolved class valid
  output logic coll_drop_out, // drop colliding packet
  output logic igmp_cpu_only_out, // Multicast_snoop_to_cpu only
  output logic irq_out // interrupt, active high
);
  swq_pkg::st_t st_r, st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [31:0] wd, setv;
    logic [9:0] tot;
    logic [6:0] pfull;
    logic [1:0] p1, tq;
    logic [3:0] w;
    logic tok, pok;
    wd = bus_in.wdata;
    setv = 32'h0;
    tot = 10'h0;
    pfull = 7'h0;
    p1 = 2'h0;
    tq = 2'h0;
    w = 4'h0;
    tok = 1'b0;
    pok = 1'b0;
    st_nxt = st_r;
    // register writes
    if (bus_in.wr) begin
      case (bus_in.addr)
        `SWQ_OFF_STATUS: st_nxt.status = st_r.status & ~wd;
        `SWQ_OFF_MASK: st_nxt.mask = (st_r.mask & ~`SWQ_MASK_WR) | (wd & `SWQ_MASK_WR);
        `SWQ_OFF_GTHR: st_nxt.gthr = wd;
        `SWQ_OFF_PTHR: st_nxt.pthr = wd[7:0];
        `SWQ_OFF_SCHED: st_nxt.sched = wd & `SWQ_SCHED_WR;
        `SWQ_OFF_PRIO: st_nxt.prio = (st_r.prio & ~`SWQ_PRIO_WR) | (wd & `SWQ_PRIO_WR);
        `SWQ_OFF_RSV: st_nxt.rsv = wd;
        `SWQ_OFF_QMAP: st_nxt.qmap = wd[31:16];
        default: ;
      endcase
    end
    // global hysteresis
    if (st_r.pause_act) begin
      st_nxt.pause_act = !(free_blocks_in > {1'b0, st_r.gthr[31:24]});
    end else begin
      st_nxt.pause_act = free_blocks_in < {1'b0, st_r.gthr[23:16]};
    end
    if (st_r.drop_act) begin
      st_nxt.drop_act = !(free_blocks_in > {1'b0, st_r.gthr[15:8]});
    end else begin
      st_nxt.drop_act = free_blocks_in < {1'b0, st_r.gthr[7:0]};
    end
    // per-port, per-class congestion
    for (int p = 0; p < PORTS; p++) begin
      tot = 10'h0;
      for (int q = 0; q < 4; q++) begin
        tot = tot + {2'b00, queued_blocks_in[p][q]};
      end
      for (int q = 0; q < 4; q++) begin
        st_nxt.cong[q][p] = (p != `SWQ_UNUSED_PORT) && (st_r.pause_act || st_r.drop_act)
          && (tot > {2'b00, st_r.pthr})
          && (queued_blocks_in[p][q] > st_r.rsv[q*8 +: 8]);
      end
      pfull[p] = |{st_nxt.cong[3][p], st_nxt.cong[2][p], st_nxt.cong[1][p],
        st_nxt.cong[0][p]};
      st_nxt.pause_port[p] = pfull[p] && st_r.pause_act && !st_r.drop_act
        && !(st_r.sched[`SWQ_BIT_TOPOFF + p] && top_class_rx_in[p]);
      st_nxt.drop_port[p] = pfull[p] && st_r.drop_act;
    end
    // hardware events; set wins over a clear in the same cycle
    setv[`SWQ_BIT_STORM] = storm_in;
    setv[`SWQ_BIT_EXHAUST] = free_blocks_in == 9'h000;
    setv[`SWQ_BIT_SHFULL] = st_r.pause_act;
    setv[`SWQ_BIT_PORTFULL +: 7] = pfull;
    st_nxt.status = (st_nxt.status | setv) & `SWQ_STATUS_IMPL;
    st_nxt.irq = |(st_nxt.status & ~st_nxt.mask);
    // weighted round robin egress
    case (st_r.cur)
      swq_pkg::CLS_VO: w = st_r.sched[15:12];
      swq_pkg::CLS_CL: w = st_r.sched[11:8];
      swq_pkg::CLS_BE: w = st_r.sched[7:4];
      swq_pkg::CLS_BK: w = st_r.sched[3:0];
      default: w = 4'h0;
    endcase
    st_nxt.grant_vld = |queue_ready_in;
    if (st_r.sched[15:12] == 4'h0 && queue_ready_in[3]) begin
      st_nxt.grant = 2'd3;
    end else if (st_r.sent == 4'h0 && !queue_ready_in[cls_idx(st_r.cur)]) begin
      st_nxt.cur = cls_next(st_r.cur); // skip idle queue
      st_nxt.grant = cls_idx(st_nxt.cur);
      st_nxt.grant_vld = 1'b0;
    end else begin
      st_nxt.grant = cls_idx(st_r.cur);
    end
    if (sent_in && st_r.grant_vld && !(st_r.grant == 2'd3 && st_r.sched[15:12] == 4'h0)) begin
      if (st_r.sent + 4'h1 >= w || st_r.sent == 4'hF) begin
        st_nxt.cur = cls_next(st_r.cur);
        st_nxt.sent = 4'h0;
        st_nxt.grant_vld = 1'b0;
      end else begin
        st_nxt.sent = st_r.sent + 4'h1;
      end
    end
    // strict voice wins even when a lower class packet just completed
    if (st_r.sched[15:12] == 4'h0 && queue_ready_in[3]) begin
      st_nxt.grant = 2'h3;
      st_nxt.grant_vld = 1'b1;
    end
    // priority resolution
    tq = st_r.qmap[cls_req_in.tag*2 +: 2];
    p1 = st_r.prio[cls_req_in.port*2 +: 2];
    tok = cls_req_in.tag_vld && st_r.prio[`SWQ_BIT_VID + cls_req_in.port];
    pok = cls_req_in.tos_vld && st_r.prio[`SWQ_BIT_TOS + cls_req_in.port];
    st_nxt.cls_vld = cls_req_in.req;
    if (cls_req_in.to_cpu && st_r.prio[`SWQ_BIT_CPUOVR]) begin
      st_nxt.cls = 2'd1;
    end else if (!st_r.prio[`SWQ_BIT_ORDER]) begin
      st_nxt.cls = tok ? tq : (pok ? cls_req_in.tos_cls : p1);
    end else begin
      st_nxt.cls = pok ? cls_req_in.tos_cls : (tok ? tq : p1);
    end
    st_nxt.coll_drop = collision_in && (attempts_in >= st_r.sched[27:24]);
    st_nxt.igmp_cpu = igmp_in && st_r.prio[`SWQ_BIT_SNOOP];
    // register reads
    st_nxt.rdata = 32'h0;
    if (bus_in.rd) begin
      case (bus_in.addr)
        `SWQ_OFF_STATUS: st_nxt.rdata = st_r.status;
        `SWQ_OFF_MASK: st_nxt.rdata = st_r.mask;
        `SWQ_OFF_GTHR: st_nxt.rdata = st_r.gthr;
        `SWQ_OFF_PTHR: st_nxt.rdata = {24'h0, st_r.pthr};
        `SWQ_OFF_SCHED: st_nxt.rdata = st_r.sched;
        `SWQ_OFF_PRIO: st_nxt.rdata = st_r.prio;
        `SWQ_OFF_RSV: st_nxt.rdata = st_r.rsv;
        `SWQ_OFF_QMAP: st_nxt.rdata = {st_r.qmap, 7'h0, free_blocks_in};
        `SWQ_OFF_CONG: st_nxt.rdata = {1'b0, st_r.cong[3], 1'b0, st_r.cong[2],
          1'b0, st_r.cong[1], 1'b0, st_r.cong[0]};
        `SWQ_OFF_LKUP: st_nxt.rdata = {29'h0, lookup_idle_in, 2'h0};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // class helpers
  function automatic logic [1:0] cls_idx(input swq_pkg::cls_oh_t c);
    case (c)
      swq_pkg::CLS_VO: cls_idx = 2'd3;
      swq_pkg::CLS_CL: cls_idx = 2'd2;
      swq_pkg::CLS_BE: cls_idx = 2'd1;
      default: cls_idx = 2'd0;
    endcase
  endfunction

  function automatic swq_pkg::cls_oh_t cls_next(input swq_pkg::cls_oh_t c);
    case (c)
      swq_pkg::CLS_VO: cls_next = swq_pkg::CLS_CL;
      swq_pkg::CLS_CL: cls_next = swq_pkg::CLS_BE;
      swq_pkg::CLS_BE: cls_next = swq_pkg::CLS_BK;
      default: cls_next = swq_pkg::CLS_VO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
      st_r.mask <= `SWQ_MASK_RST;
      st_r.gthr <= `SWQ_GTHR_RST;
      st_r.pthr <= `SWQ_PTHR_RST;
      st_r.sched <= `SWQ_SCHED_RST;
      st_r.prio <= `SWQ_PRIO_RST;
      st_r.rsv <= `SWQ_RSV_RST;
      st_r.qmap <= `SWQ_QMAP_RST;
      st_r.cur <= swq_pkg::CLS_VO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign pause_port_out = st_r.pause_port;
  assign drop_port_out = st_r.drop_port;
  assign grant_out = st_r.grant;
  assign grant_vld_out = st_r.grant_vld;
  assign cls_out = st_r.cls;
  assign cls_vld_out = st_r.cls_vld;
  assign coll_drop_out = st_r.coll_drop;
  assign igmp_cpu_only_out = st_r.igmp_cpu;
  assign irq_out = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence storm_seen;
    storm_in;
  endsequence
  storm_flag_a: assert property (storm_seen |=> st_r.status[25])
    else $error("storm flag not set");
  exhaust_flag_a: assert property (free_blocks_in == 9'h000 |=> st_r.status[24])
    else $error("exhausted flag not set");
  status_clear_a: assert property (bus_in.wr && bus_in.addr == 8'h00 && bus_in.wdata[23]
    && !st_r.pause_act |=> !st_r.status[23])
    else $error("shared full flag not cleared");
  port5_flag_a: assert property (!st_r.status[19] && st_r.mask[19])
    else $error("port 5 flag or mask changed");
  irq_level_a: assert property (irq_out == |(st_r.status & ~st_r.mask))
    else $error("interrupt level wrong");
  pause_set_a: assert property (!st_r.pause_act && free_blocks_in < {1'b0, st_r.gthr[23:16]}
    |=> st_r.pause_act)
    else $error("pause not entered");
  pause_hold_a: assert property (st_r.pause_act && free_blocks_in <= {1'b0, st_r.gthr[31:24]}
    |=> st_r.pause_act)
    else $error("pause released early");
  drop_set_a: assert property (!st_r.drop_act && free_blocks_in < {1'b0, st_r.gthr[7:0]}
    |=> st_r.drop_act)
    else $error("drop not entered");
  no_cong_a: assert property (!st_r.pause_act && !st_r.drop_act |=> st_r.cong == '0)
    else $error("congestion without threshold");
  coll_drop_a: assert property (collision_in && attempts_in >= st_r.sched[27:24]
    |=> coll_drop_out)
    else $error("collision drop missing");
  strict_voice_a: assert property (st_r.sched[15:12] == 4'h0 && queue_ready_in[3]
    |=> grant_out == 2'd3 && grant_vld_out)
    else $error("voice not strict");
  cpu_override_a: assert property (cls_req_in.req && cls_req_in.to_cpu && st_r.prio[31]
    |=> cls_vld_out && cls_out == 2'd1)
    else $error("cpu override ignored");
  igmp_cpu_a: assert property (igmp_in && st_r.prio[23] |=> igmp_cpu_only_out)
    else $error("igmp snoop ignored");
  igmp_flood_a: assert property (!(igmp_in && st_r.prio[23]) |=> !igmp_cpu_only_out)
    else $error("igmp not flooded");
  pause_release_a: assert property (st_r.pause_act
    && free_blocks_in > {1'b0, st_r.gthr[31:24]} |=> !st_r.pause_act)
    else $error("pause not released");
  drop_hold_a: assert property (st_r.drop_act
    && free_blocks_in <= {1'b0, st_r.gthr[15:8]} |=> st_r.drop_act)
    else $error("drop released early");
  drop_release_a: assert property (st_r.drop_act
    && free_blocks_in > {1'b0, st_r.gthr[15:8]} |=> !st_r.drop_act)
    else $error("drop not released");
  drop_only_a: assert property ((pause_port_out & drop_port_out) == 7'h00)
    else $error("pause and drop on one port");
  port5_quiet_a: assert property (st_r.prio[11:10] == 2'h1
    && !pause_port_out[5] && !drop_port_out[5])
    else $error("port 5 field or output active");
  top_off_a: assert property (st_r.sched[16] && top_class_rx_in[0]
    |=> !pause_port_out[0])
    else $error("top class did not lift pause");
  mask_fixed_a: assert property (!st_r.mask[30] && st_r.mask[22:21] == 2'h0
    && st_r.mask[13:0] == 14'h0000)
    else $error("reserved mask bit set");
  status_res_a: assert property ((st_r.status & ~`SWQ_STATUS_IMPL) == 32'h0)
    else $error("reserved status bit set");
  queue_full_a: assert property (drop_port_out[0] || pause_port_out[0]
    |-> st_r.status[14])
    else $error("port full flag missing");
  shared_full_a: assert property (st_r.pause_act |=> st_r.status[23])
    else $error("shared full flag missing");
  free_read_a: assert property (bus_in.rd && bus_in.addr == `SWQ_OFF_QMAP
    |=> rdata_out[8:0] == $past(free_blocks_in))
    else $error("free count read wrong");
  cong_read_a: assert property (bus_in.rd && bus_in.addr == `SWQ_OFF_CONG
    |=> rdata_out[30:24] == $past(st_r.cong[3]))
    else $error("congestion read wrong");
  coll_keep_a: assert property (collision_in
    && attempts_in < st_r.sched[27:24] |=> !coll_drop_out)
    else $error("collision dropped early");
  default_class_a: assert property (cls_req_in.req && cls_req_in.port == 3'h0
    && !st_r.prio[16] && !st_r.prio[24] && !cls_req_in.to_cpu && !bus_in.wr
    |=> cls_vld_out && cls_out == st_r.prio[1:0])
    else $error("port default class not used");
  tos_first_a: assert property (cls_req_in.req && cls_req_in.tos_vld
    && cls_req_in.port == 3'h0 && st_r.prio[24] && st_r.prio[15] && !cls_req_in.to_cpu
    |=> cls_out == $past(cls_req_in.tos_cls))
    else $error("tos class not first");
  vid_tag_a: assert property (cls_req_in.req && cls_req_in.tag_vld
    && cls_req_in.tag == 3'h7 && cls_req_in.port == 3'h0 && st_r.prio[16]
    && !st_r.prio[15] && !cls_req_in.to_cpu && !bus_in.wr
    |=> cls_out == st_r.qmap[15:14])
    else $error("tag map class not used");

  ////////////////////////////////////////////////////////////////////////////
  // egress rotation steps
  sequence last_bk_pkt;
    sent_in && st_r.grant_vld && st_r.grant == 2'h0 && st_r.cur == swq_pkg::CLS_BK
      && st_r.sent + 4'h1 >= st_r.sched[3:0];
  endsequence
  sequence back_to_voice;
    st_r.cur == swq_pkg::CLS_VO && st_r.sent == 4'h0;
  endsequence
  sequence mid_cl_pkt;
    sent_in && st_r.grant_vld && st_r.grant == 2'h2 && st_r.cur == swq_pkg::CLS_CL
      && queue_ready_in[2] && st_r.sent != 4'hF
      && st_r.sent + 4'h1 < st_r.sched[11:8];
  endsequence
  wrr_wrap_a: assert property (last_bk_pkt |=> back_to_voice)
    else $error("rotation did not return to voice");
  wrr_count_a: assert property (mid_cl_pkt |=> st_r.cur == swq_pkg::CLS_CL
    && st_r.sent == $past(st_r.sent) + 4'h1)
    else $error("weight count wrong");
endmodule

// ===== rtl/swq_cfg.svh
// Purpose: offsets, field positions, reset values of the queue/QoS block
// Assumes: 32-bit word registers, byte offsets
// Notes: definitions only
`ifndef SWQ_CFG_SVH
`define SWQ_CFG_SVH
`define SWQ_OFF_STATUS 8'h00
`define SWQ_OFF_MASK 8'h04
`define SWQ_OFF_GTHR 8'h08
`define SWQ_OFF_PTHR 8'h0C
`define SWQ_OFF_SCHED 8'h10
`define SWQ_OFF_PRIO 8'h14
`define SWQ_OFF_RSV 8'h18
`define SWQ_OFF_QMAP 8'h1C
`define SWQ_OFF_CONG 8'h20
`define SWQ_OFF_LKUP 8'h24
`define SWQ_BIT_STORM 25
`define SWQ_BIT_EXHAUST 24
`define SWQ_BIT_SHFULL 23
`define SWQ_BIT_PORTFULL 14
`define SWQ_BIT_CPUOVR 31
`define SWQ_BIT_TOS 24
`define SWQ_BIT_SNOOP 23
`define SWQ_BIT_VID 16
`define SWQ_BIT_ORDER 15
`define SWQ_BIT_TOPOFF 16
`define SWQ_BIT_LKIDLE 2
`define SWQ_STATUS_IMPL 32'h0397C000
`define SWQ_MASK_WR 32'hBF97C000
`define SWQ_MASK_RST 32'hBF9FC000
`define SWQ_GTHR_RST 32'hFFC86E5A
`define SWQ_PTHR_RST 8'h14
`define SWQ_SCHED_WR 32'h0F7FFFFF
`define SWQ_SCHED_RST 32'h0F000000
`define SWQ_PRIO_WR 32'hDFDFB3FF
`define SWQ_PRIO_RST 32'h00001555
`define SWQ_RSV_RST 32'h03030303
`define SWQ_QMAP_RST 16'hFA41
`define SWQ_FREE_RST 9'h16E
`define SWQ_UNUSED_PORT 5
`endif

// ===== rtl/swq_pkg.sv
// Purpose: types of the queue/QoS block
// Assumes: 7 ports, 4 classes (3 voice .. 0 background)
// Notes: none
package swq_pkg;
  typedef logic [3:0][7:0] port_blk_t;
  typedef enum logic [3:0] {
    CLS_BK = 4'h1,
    CLS_BE = 4'h2,
    CLS_CL = 4'h4,
    CLS_VO = 4'h8
  } cls_oh_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic req;
    logic [2:0] port;
    logic tag_vld;
    logic [2:0] tag;
    logic tos_vld;
    logic [1:0] tos_cls;
    logic to_cpu;
  } cls_req_t;
  typedef struct packed {
    logic [31:0] mask, status, gthr, sched, prio, rsv, rdata;
    logic [7:0] pthr;
    logic [15:0] qmap;
    logic pause_act, drop_act;
    logic [3:0][6:0] cong;
    logic [6:0] pause_port, drop_port;
    cls_oh_t cur;
    logic [3:0] sent;
    logic [1:0] grant;
    logic grant_vld;
    logic [1:0] cls;
    logic cls_vld;
    logic coll_drop, igmp_cpu, irq;
  } st_t;
endpackage

// ===== verification/switch_queue_qos_test.sv
// Purpose: self-checking bench of the queue/QoS block
// Assumes: register port answers one cycle after a read strobe
// Notes: inputs driven by non-blocking assignment, at the rising edge or 1 ns after it
`timescale 1ns/1ps
module switch_queue_qos_test;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  swq_pkg::bus_req_t bus = '0;
  swq_pkg::cls_req_t creq = '0;
  swq_pkg::port_blk_t [6:0] queued = '0;
  logic [8:0] free = 9'h16E;
  logic storm = 1'b0;
  logic [6:0] top_rx = 7'h00;
  logic coll = 1'b0;
  logic [3:0] att = 4'h0;
  logic [3:0] ready = 4'h0;
  logic sent = 1'b0;
  logic igmp = 1'b0;
  logic lk_idle = 1'b0;
  logic [31:0] rdata;
  logic [6:0] pause_p, drop_p;
  logic [1:0] grant, cls;
  logic grant_vld, cls_vld, coll_drop, igmp_cpu, irq;
  int n_errors = 0;
  int samples_checked = 0;
  localparam logic [7:0] OFFS [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
    8'h1C, 8'h20, 8'h40};
  localparam logic [31:0] RSTV [10] = '{32'h0, 32'hBF9FC000, 32'hFFC86E5A, 32'h14,
    32'h0F000000, 32'h1555, 32'h03030303, 32'hFA41016E, 32'h0, 32'h0};
  localparam logic [15:0] TAG_MAP = 16'hFA41;

  always #20 core_clk_in = ~core_clk_in;

  switch_queue_qos dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .bus_in(bus),
    .rdata_out(rdata), .free_blocks_in(free), .queued_blocks_in(queued), .storm_in(storm),
    .top_class_rx_in(top_rx), .collision_in(coll), .attempts_in(att),
    .queue_ready_in(ready), .sent_in(sent), .cls_req_in(creq), .igmp_in(igmp),
    .lookup_idle_in(lk_idle), .pause_port_out(pause_p), .drop_port_out(drop_p),
    .grant_out(grant), .grant_vld_out(grant_vld), .cls_out(cls), .cls_vld_out(cls_vld),
    .coll_drop_out(coll_drop), .igmp_cpu_only_out(igmp_cpu), .irq_out(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk_in);
    bus.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk_in);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // wait for a grant, compare its class, then report one packet sent
  task automatic serve(input logic [1:0] exp);
    int k;
    k = 0;
    while (grant_vld !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    chk({31'h0, grant_vld}, 32'h1);
    chk({30'h0, grant}, {30'h0, exp});
    @(posedge core_clk_in);
    sent <= 1'b1;
    @(posedge core_clk_in);
    sent <= 1'b0;
    #1;
  endtask

  task automatic classify(input logic [2:0] p, input logic tv, input logic [2:0] tag,
      input logic sv, input logic [1:0] tc, input logic cpu, input logic [1:0] exp);
    @(posedge core_clk_in);
    creq <= '{1'b1, p, tv, tag, sv, tc, cpu};
    @(posedge core_clk_in);
    creq.req <= 1'b0;
    #1;
    chk({31'h0, cls_vld}, 32'h1);
    chk({30'h0, cls}, {30'h0, exp});
  endtask

  task automatic collide(input logic [3:0] a, input logic exp);
    @(posedge core_clk_in);
    coll <= 1'b1;
    att <= a;
    @(posedge core_clk_in);
    coll <= 1'b0;
    #1;
    chk({31'h0, coll_drop}, {31'h0, exp});
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 4000);
    n_errors++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    for (int j = 0; j < 10; j++) reg_rd(OFFS[j], RSTV[j]);
    reg_wr(8'h1C, 32'h0000FFFF);
    reg_rd(8'h1C, 32'h0000016E);
    reg_wr(8'h1C, 32'hFA410000);
    lk_idle <= 1'b1;
    reg_rd(8'h24, 32'h4);
    $display("test register reset done");
    // storm event, masked then unmasked, then write-one-to-clear
    storm <= 1'b1;
    step(2);
    storm <= 1'b0;
    reg_rd(8'h00, 32'h02000000);
    chk({31'h0, irq}, 32'h0);
    reg_wr(8'h04, 32'h0);
    reg_rd(8'h04, 32'h00080000);
    step(2);
    chk({31'h0, irq}, 32'h1);
    reg_wr(8'h00, 32'h02000000);
    reg_rd(8'h00, 32'h0);
    step(1);
    chk({31'h0, irq}, 32'h0);
    free <= 9'h000;
    step(3);
    free <= 9'h16E;
    step(3);
    reg_rd(8'h00, 32'h01800000);
    reg_wr(8'h00, 32'hFFFFFFFF);
    reg_rd(8'h00, 32'h0);
    $display("test event flags done");
    // congestion at the port level boundary, then drop and pause hysteresis
    queued[0][3] <= 8'h14;
    free <= 9'h050;
    step(4);
    chk({25'h0, drop_p}, 32'h0);
    queued[0][3] <= 8'h20;
    step(4);
    chk({25'h0, drop_p}, 32'h1);
    chk({25'h0, pause_p}, 32'h0);
    reg_rd(8'h20, 32'h01000000);
    reg_rd(8'h00, 32'h00804000);
    free <= 9'h060;
    step(3);
    chk({25'h0, drop_p}, 32'h1);
    free <= 9'h070;
    step(3);
    chk({25'h0, drop_p}, 32'h0);
    chk({25'h0, pause_p}, 32'h1);
    reg_wr(8'h10, 32'h0F011213);
    top_rx <= 7'h01;
    step(3);
    chk({25'h0, pause_p}, 32'h0);
    top_rx <= 7'h00;
    free <= 9'h0F0;
    step(3);
    chk({25'h0, pause_p}, 32'h1);
    free <= 9'h100;
    step(3);
    chk({25'h0, pause_p}, 32'h0);
    queued[0][3] <= 8'h00;
    free <= 9'h16E;
    reg_wr(8'h00, 32'hFFFFFFFF);
    reg_wr(8'h04, 32'hFFFFFFFF);
    $display("test flow control done");
    // collision limit at its reset value, then at 3
    collide(4'hE, 1'b0);
    collide(4'hF, 1'b1);
    reg_wr(8'h10, 32'h03001213);
    collide(4'h2, 1'b0);
    collide(4'h3, 1'b1);
    $display("test collision done");
    // voice weight zero is strict, then weighted rotation
    reg_wr(8'h10, 32'h0F000213);
    ready <= 4'hF;
    repeat (3) serve(2'h3);
    ready <= 4'h0;
    reg_wr(8'h10, 32'h0F001213);
    ready <= 4'h8;
    serve(2'h3);
    ready <= 4'hF;
    repeat (2) serve(2'h2);
    serve(2'h1);
    repeat (3) serve(2'h0);
    serve(2'h3);
    serve(2'h2);
    ready <= 4'h0;
    $display("test scheduler done");
    // priority resolution
    classify(3'h0, 1'b1, 3'h7, 1'b1, 2'h2, 1'b0, 2'h1);
    reg_wr(8'h14, 32'h01811555);
    for (int t = 0; t < 8; t++) classify(3'h0, 1'b1, t[2:0], 1'b0, 2'h0, 1'b0,
      TAG_MAP[2*t+:2]);
    classify(3'h0, 1'b1, 3'h7, 1'b1, 2'h2, 1'b0, 2'h3);
    classify(3'h0, 1'b0, 3'h0, 1'b1, 2'h2, 1'b0, 2'h2);
    classify(3'h1, 1'b1, 3'h7, 1'b1, 2'h2, 1'b0, 2'h1);
    reg_wr(8'h14, 32'h01819555);
    classify(3'h0, 1'b1, 3'h7, 1'b1, 2'h2, 1'b0, 2'h2);
    reg_wr(8'h14, 32'h81819555);
    classify(3'h0, 1'b1, 3'h7, 1'b1, 2'h2, 1'b1, 2'h1);
    igmp <= 1'b1;
    step(2);
    chk({31'h0, igmp_cpu}, 32'h1);
    reg_wr(8'h14, 32'h00001555);
    step(2);
    chk({31'h0, igmp_cpu}, 32'h0);
    reg_wr(8'h14, 32'hFFFFFFFF);
    reg_rd(8'h14, 32'hDFDFB7FF);
    $display("test classification done");
    conclude();
  end
endmodule
